// file: design/spram_mem.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01 - write data width equals read data width
// R02 - one address serves reads and writes
// R03 - memory written only while write enable high
// R04 - address hold keeps previously registered address
// R05 - single mode: one clock times every register
// R06 - read/write mode: write clock times write ports
// R07 - input/output mode: input clock samples inputs
// R08 - independent mode: port clock times all registers
// R09 - main clock enable low holds its registers
// R10 - output updates only while read enable high
// R11 - clear input empties registered ports at once
// R12 - clear reach chosen separately per port
// R13 - split ports in single mode share clock
// R14 - read/write split: input side times writes
// R15 - read/write split: output side times reads
// R16 - input/output: q registered on output side
// R17 - separate input and output clock enables
// R18 - read word shown on read data bus
// R19 - new-data: enabled bytes flow, masked show old
// R20 - q reads zero after power-up until read
// R21 - accesses act on rising edge when enabled
module spram_mem #(
    parameter spram_pkg::clk_mode_e MODE = spram_pkg::MODE_SINGLE,
    parameter bit SPLIT_CLK = 1'b0,
    parameter bit CLR_INDATA = 1'b1,
    parameter bit CLR_ADDR = 1'b1,
    parameter bit CLR_WREN = 1'b1,
    parameter bit CLR_MASK = 1'b1,
    parameter bit CLR_RDEN = 1'b1,
    parameter bit CLR_Q = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    spram_if.mem_mp pins
);
    import spram_pkg::*;

    // clear lines per registered port; a port whose option is off never sees aclr
    logic clr_data;
    logic clr_addr;
    logic clr_wren;
    logic clr_mask;
    logic clr_rden;
    logic clr_q;

    assign clr_data = pins.aclr & CLR_INDATA; // [R11] [R12]
    assign clr_addr = pins.aclr & CLR_ADDR; // [R12]
    assign clr_wren = pins.aclr & CLR_WREN; // [R12]
    assign clr_mask = pins.aclr & CLR_MASK; // [R12]
    assign clr_rden = pins.aclr & CLR_RDEN; // [R12]
    assign clr_q = pins.aclr & CLR_Q; // [R12]

    // enables for the two register groups; everything runs on clk, the mode only
    // decides which enable pin holds which group
    logic in_en;
    logic out_en;

    always_comb begin
        case (MODE)
            MODE_SINGLE: begin
                // one clock; split ports share it and both side enables still apply
                in_en = pins.clkena & (~SPLIT_CLK | pins.inclocken); // [R05] [R13] [R09]
                out_en = pins.clkena & (~SPLIT_CLK | pins.outclocken); // [R13] [R17]
            end
            MODE_RD_WR: begin
                // write side on the input clock port, read side on the output one
                in_en = pins.clkena & pins.inclocken; // [R06] [R14] [R17]
                out_en = pins.outclocken; // [R15] [R17]
            end
            MODE_IN_OUT: begin
                in_en = pins.clkena & pins.inclocken; // [R07] [R17]
                out_en = pins.outclocken; // [R16] [R17]
            end
            MODE_INDEP: begin
                // port a clock drives every register of this port
                in_en = pins.clkena; // [R08] [R09]
                out_en = pins.clkena; // [R08]
            end
            default: begin
                // unreachable for a legal mode; the main enable alone then gates both
                in_en = pins.clkena;
                out_en = pins.clkena;
            end
        endcase
    end

    // address register serves both groups in read/write mode, so either enable may load it;
    // hold still wins, which keeps a stalled read pointed at its word
    logic addr_en;
    assign addr_en = (MODE == MODE_RD_WR) ? (in_en | out_en) : in_en;

    // read enable capture follows the output group in read/write mode, else the input group
    logic rd_cap_en;
    assign rd_cap_en = (MODE == MODE_RD_WR) ? out_en : in_en; // [R15]

    // input registers and the q output register
    word_t data_reg;
    addr_t addr_reg;
    logic wren_reg;
    mask_t mask_reg;
    logic rden_reg;
    word_t q_reg;

    // write data register
    always_ff @(posedge clk or posedge clr_data) begin
        if (clr_data) begin
            data_reg <= DATA_RST; // [R11]
        end else if (!rstn) begin
            data_reg <= DATA_RST;
        end else if (in_en) begin
            data_reg <= pins.data; // [R01] [R21]
        end
    end

    // shared address register; hold freezes it, the pin is then ignored
    always_ff @(posedge clk or posedge clr_addr) begin
        if (clr_addr) begin
            addr_reg <= ADDR_RST; // [R11]
        end else if (!rstn) begin
            addr_reg <= ADDR_RST;
        end else if (addr_en && !pins.addr_hold) begin // [R04] [R09]
            addr_reg <= pins.address; // [R02]
        end
    end

    // write enable register
    always_ff @(posedge clk or posedge clr_wren) begin
        if (clr_wren) begin
            wren_reg <= 1'b0; // [R11]
        end else if (!rstn) begin
            wren_reg <= 1'b0;
        end else if (in_en) begin
            wren_reg <= pins.wren; // [R06]
        end
    end

    // byte mask register
    always_ff @(posedge clk or posedge clr_mask) begin
        if (clr_mask) begin
            mask_reg <= MASK_RST; // [R11]
        end else if (!rstn) begin
            mask_reg <= MASK_RST;
        end else if (in_en) begin
            mask_reg <= pins.byte_mask; // [R14]
        end
    end

    // read enable register sits in the read group in read/write mode, else in the input group
    always_ff @(posedge clk or posedge clr_rden) begin
        if (clr_rden) begin
            rden_reg <= 1'b0; // [R11]
        end else if (!rstn) begin
            rden_reg <= 1'b0;
        end else if (rd_cap_en) begin
            rden_reg <= pins.rden; // [R15]
        end
    end

    // a write commits one edge after capture, only if the write group is enabled;
    // a write caught just before the group stalls waits in wren_reg for the enable
    logic do_write;
    assign do_write = wren_reg & in_en; // [R03] [R21]

    // q loads only on an enabled output edge that carries a captured read
    logic q_load;
    assign q_load = out_en & rden_reg; // [R10] [R16]

    // storage in byte lanes so each lane array has one writer; never reset,
    // so the stored words survive both rstn and a clear
    word_t old_word;
    word_t merged;

    genvar b;
    generate
        for (b = 0; b < MASK_W; b++) begin : g_byte
            logic [BYTE_W-1:0] lane_mem [DEPTH];

            // a lane takes the write only where its mask bit is set
            always_ff @(posedge clk) begin
                if (do_write && mask_reg[b]) begin
                    lane_mem[addr_reg] <= data_reg[b*BYTE_W +: BYTE_W]; // [R03]
                end
            end
            assign old_word[b*BYTE_W +: BYTE_W] = lane_mem[addr_reg];
            // new-data read-during-write view of this byte
            assign merged[b*BYTE_W +: BYTE_W] = (do_write && mask_reg[b]) ?
                data_reg[b*BYTE_W +: BYTE_W] : old_word[b*BYTE_W +: BYTE_W]; // [R19]
        end
    endgenerate

    // output register: zero from reset until the first enabled read
    always_ff @(posedge clk or posedge clr_q) begin
        if (clr_q) begin
            q_reg <= Q_RST; // [R11]
        end else if (!rstn) begin
            q_reg <= Q_RST; // [R20]
        end else if (q_load) begin
            q_reg <= merged; // [R19] [R21]
        end
    end

    // q comes straight off its flop; nothing sits between register and pin
    assign pins.q = q_reg; // [R18]

endmodule // spram_mem
`default_nettype wire

// file: pkg/spram_pkg.sv
// shared widths, clock-mode codes and reset values for the single-port ram
package spram_pkg;

    // word and address geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int DEPTH = 256;
    localparam int BYTE_W = 8;
    localparam int MASK_W = DATA_W / BYTE_W;

    // clocking modes; all of them run on the one clk, the mode picks which enable
    // gates which register group
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_RD_WR = 2'h1,
        MODE_IN_OUT = 2'h2,
        MODE_INDEP = 2'h3
    } clk_mode_e;

    typedef logic [DATA_W-1:0] word_t;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [MASK_W-1:0] mask_t;

    // reset values of the registered ports
    localparam word_t DATA_RST = 32'h0000_0000;
    localparam word_t Q_RST = 32'h0000_0000;
    localparam addr_t ADDR_RST = 8'h00;
    localparam mask_t MASK_RST = 4'h0;
    localparam mask_t MASK_ALL = 4'hF;

    // pipeline depth from command pins to read data on q
    localparam int RD_LAT = 2;

endpackage

// file: pkg/spram_if.sv
`timescale 1ns/1ps
`default_nettype none
// pins between user logic and the ram end; no clocking block, the bench owns clk
interface spram_if;
    import spram_pkg::*;

    word_t data;
    addr_t address;
    logic wren;
    logic rden;
    logic addr_hold;
    mask_t byte_mask;
    logic clkena;
    logic inclocken;
    logic outclocken;
    logic aclr;
    word_t q;

    modport mem_mp (
        input data,
        input address,
        input wren,
        input rden,
        input addr_hold,
        input byte_mask,
        input clkena,
        input inclocken,
        input outclocken,
        input aclr,
        output q
    );

    modport user_mp (
        output data,
        output address,
        output wren,
        output rden,
        output addr_hold,
        output byte_mask,
        output clkena,
        output inclocken,
        output outclocken,
        output aclr,
        input q
    );
endinterface
`default_nettype wire

// file: design/spram_user.sv
`timescale 1ns/1ps
`default_nettype none
// user logic end: registers commands onto the ram pins and returns read words
module spram_user (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire spram_pkg::addr_t cmd_addr,
    input wire spram_pkg::word_t cmd_data,
    input wire spram_pkg::mask_t cmd_mask,
    input wire logic cmd_hold,
    input wire logic en_main,
    input wire logic en_in,
    input wire logic en_out,
    input wire logic clear,
    output logic rd_valid,
    output spram_pkg::word_t rd_data,
    spram_if.user_mp pins
);
    import spram_pkg::*;

    word_t data_reg;
    addr_t addr_reg;
    logic wren_reg;
    logic rden_reg;
    logic hold_reg;
    mask_t mask_reg;
    logic [RD_LAT-1:0] pend_reg;

    // drive pins from flops; same data width both ways
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_reg <= DATA_RST;
            addr_reg <= ADDR_RST;
            wren_reg <= 1'b0;
            rden_reg <= 1'b0;
            hold_reg <= 1'b0;
            mask_reg <= MASK_ALL;
        end else begin
            data_reg <= cmd_data; // [R01]
            addr_reg <= cmd_addr;
            wren_reg <= cmd_write;
            rden_reg <= cmd_read;
            hold_reg <= cmd_hold;
            mask_reg <= cmd_mask;
        end
    end

    // enables and clear pass straight through; this end keeps one clock for all modes
    assign pins.data = data_reg; // [R05]
    assign pins.address = addr_reg;
    assign pins.wren = wren_reg;
    assign pins.rden = rden_reg;
    assign pins.addr_hold = hold_reg;
    assign pins.byte_mask = mask_reg; // [R06] [R14]
    assign pins.clkena = en_main; // [R07] [R08]
    assign pins.inclocken = en_in; // [R13]
    assign pins.outclocken = en_out; // [R15]
    assign pins.aclr = clear;

    // read tracking assumes enables held high; a stalled read is not retimed
    always_ff @(posedge clk) begin
        if (!rstn || clear) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= {pend_reg[RD_LAT-2:0], rden_reg};
        end
    end

    // capture returned word when its read completes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            rd_data <= DATA_RST;
        end else begin
            rd_valid <= pend_reg[RD_LAT-1];
            if (pend_reg[RD_LAT-1]) begin
                rd_data <= pins.q;
            end
        end
    end

endmodule // spram_user
`default_nettype wire

// file: tb/spram_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// pin checks for single clock mode with split ports: clkena gates both register
// groups, inclocken the input side and outclocken the output side
module spram_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire spram_pkg::word_t data,
    input wire logic wren,
    input wire logic rden,
    input wire logic addr_hold,
    input wire spram_pkg::mask_t byte_mask,
    input wire logic clkena,
    input wire logic inclocken,
    input wire logic outclocken,
    input wire logic aclr,
    input wire spram_pkg::word_t q
);
    import spram_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    word_t bm_w;
    logic both_en;

    // all three enables high: both register groups move on this edge
    assign both_en = clkena & inclocken & outclocken;

    // byte mask spread to bit lanes
    always_comb begin
        for (int b = 0; b < MASK_W; b++) begin
            bm_w[b*BYTE_W +: BYTE_W] = {BYTE_W{byte_mask[b]}};
        end
    end

    // q never moves out of reset, clear or a stalled enable
    a_clear_empties_q: assert property (aclr |-> q == Q_RST)
        else $error("q not cleared by aclr");
    a_reset_zeroes_q: assert property (disable iff (1'b0) !rstn |=> q == Q_RST)
        else $error("q not zero after reset");
    a_read_gated_q: assert property (
        clkena && inclocken && !rden ##1 !aclr [*2] |-> $stable(q))
        else $error("q moved without read enable");
    a_clkena_holds_q: assert property (
        !(clkena && outclocken) ##1 !aclr |-> $stable(q))
        else $error("q moved with clock enable low");
    a_update_needs_en: assert property (
        $changed(q) && !aclr && $past(rstn) && !$past(aclr)
        |-> $past(clkena) && $past(outclocken))
        else $error("q changed without enabled edge");
    // enabled bytes of a read-during-write show the new data two edges on
    a_new_data_flow: assert property (
        wren && rden && both_en && !aclr ##1 both_en && !aclr ##1 !aclr
        |-> (q & $past(bm_w, 2)) == ($past(data, 2) & $past(bm_w, 2)))
        else $error("written bytes did not flow to q");
    a_hold_keeps_addr: assert property (
        rden && !wren && both_en && !aclr ##1 rden && !wren && addr_hold && both_en && !aclr
        ##1 both_en && !aclr ##1 !aclr |-> $stable(q))
        else $error("held address not reused");
    a_clear_keeps_zero: assert property (aclr ##1 !aclr && !rden ##1 !aclr |-> q == Q_RST)
        else $error("q left zero after clear");
endmodule // spram_monitor
`default_nettype wire

// file: tb/test_single_port_ram.sv
`timescale 1ns/1ps
`default_nettype none
// user end and ram end face each other; the bench drives commands at negedge
module test_single_port_ram;
    import spram_pkg::*;
    logic clk;
    logic rstn;
    logic cmd_write, cmd_read, cmd_hold, en_main, en_in, en_out, clear, rd_valid;
    addr_t cmd_addr;
    word_t cmd_data, rd_data;
    mask_t cmd_mask;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    spram_if bus ();
    // split ports in single mode, so the side enables are live and can be tested
    spram_mem #(.SPLIT_CLK(1'b1)) spram_mem_inst (.clk(clk), .rstn(rstn), .pins(bus.mem_mp));
    spram_user spram_user_inst (.clk(clk), .rstn(rstn), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_mask(cmd_mask),
        .cmd_hold(cmd_hold), .en_main(en_main), .en_in(en_in), .en_out(en_out),
        .clear(clear), .rd_valid(rd_valid), .rd_data(rd_data), .pins(bus.user_mp));
    spram_monitor spram_monitor_inst (.clk(clk), .rstn(rstn), .data(bus.data),
        .wren(bus.wren), .rden(bus.rden), .addr_hold(bus.addr_hold),
        .byte_mask(bus.byte_mask), .clkena(bus.clkena), .inclocken(bus.inclocken),
        .outclocken(bus.outclocken), .aclr(bus.aclr), .q(bus.q));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic final_report;
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            final_report;
        end
    end

    task automatic check_word(input string name, input word_t exp, input word_t got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one command per cycle, held until the next falling edge
    task automatic cmd(input logic w, input logic r, input addr_t a, input word_t d,
        input mask_t m, input logic h);
        {cmd_write, cmd_read, cmd_addr, cmd_data, cmd_mask, cmd_hold} = {w, r, a, d, m, h};
        @(negedge clk);
    endtask

    task automatic idle;
        cmd(1'b0, 1'b0, 8'h00, 32'h0000_0000, MASK_ALL, 1'b0);
    endtask

    // steps first so a pulse already counted is not taken twice
    task automatic expect_rd(input word_t exp);
        @(negedge clk);
        repeat (8) if (rd_valid !== 1'b1) @(negedge clk);
        check_word("rd_valid", 32'h0000_0001, word_t'(rd_valid));
        check_word("rd_data", exp, rd_data);
    endtask

    task automatic rd(input addr_t a, input word_t exp);
        cmd(1'b0, 1'b1, a, 32'h0000_0000, MASK_ALL, 1'b0);
        idle;
        expect_rd(exp);
    endtask

    initial begin
        {cmd_write, cmd_read, cmd_addr, cmd_data, cmd_hold, clear} = '0;
        {cmd_mask, en_main, en_in, en_out, rstn} = {MASK_ALL, 4'hE};
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check_word("q", Q_RST, bus.q);
        // back-to-back writes at both ends of the address range
        for (int i = 0; i < 4; i++) cmd(1'b1, 1'b0, addr_t'(i * 85), 32'hA5C3_0000 + i,
            MASK_ALL, 1'b0);
        idle;
        for (int i = 0; i < 4; i++) rd(addr_t'(i * 85), 32'hA5C3_0000 + i);
        // a read with data on the bus must not write it
        cmd(1'b0, 1'b1, 8'h55, 32'hFFFF_FFFF, MASK_ALL, 1'b0);
        idle;
        expect_rd(32'hA5C3_0001);
        rd(8'h55, 32'hA5C3_0001);
        // read-during-write, middle bytes enabled only
        cmd(1'b1, 1'b1, 8'hAA, 32'h1122_3344, 4'h6, 1'b0);
        idle;
        expect_rd(32'hA522_3302);
        rd(8'hAA, 32'hA522_3302);
        // write without read leaves q alone
        cmd(1'b1, 1'b0, 8'h10, 32'h0BAD_F00D, MASK_ALL, 1'b0);
        repeat (4) idle;
        check_word("q", 32'hA522_3302, bus.q);
        // a write issued while the main, then the input-side, enable is low is lost
        for (int k = 0; k < 2; k++) begin
            {en_main, en_in} = (k == 0) ? 2'h1 : 2'h2;
            cmd(1'b1, 1'b0, 8'h10, 32'h1234_5678, MASK_ALL, 1'b0);
            repeat (4) idle;
            {en_main, en_in} = 2'h3;
            rd(8'h10, 32'h0BAD_F00D);
        end
        // output-side enable low: the read is taken but q keeps its last word
        en_out = 1'b0;
        cmd(1'b0, 1'b1, 8'hAA, 32'h0000_0000, MASK_ALL, 1'b0);
        idle;
        expect_rd(32'h0BAD_F00D);
        en_out = 1'b1;
        // second read holds the first address
        cmd(1'b0, 1'b1, 8'h00, 32'h0000_0000, MASK_ALL, 1'b0);
        cmd(1'b0, 1'b1, 8'hFF, 32'h0000_0000, MASK_ALL, 1'b1);
        idle;
        expect_rd(32'hA5C3_0000);
        expect_rd(32'hA5C3_0000);
        // clear drops q at once but the array survives
        clear = 1'b1;
        #1 check_word("q", Q_RST, bus.q);
        @(negedge clk);
        clear = 1'b0;
        rd(8'hFF, 32'hA5C3_0003);
        final_report;
    end
endmodule // test_single_port_ram
`default_nettype wire
